// file: hdl/config_memory_crc_checker.sv
// Configuration memory soft-error CRC checker, top level
//==============================================================
// Functional notes
// RQ1 - Error flag high when corrupted configuration bits found, low otherwise.
// RQ2 - Flag is open-drain: pulls low or releases; present only when enabled (code keeps the pin and holds it pulled low when ERR_DETECT_EN is 0).
// RQ3 - One 32-bit CRC covers the whole configuration cell memory.
// RQ4 - Each configuration frame carries a 16-bit CRC shifted in after data.
// RQ5 - Frame CRC mismatch drives configuration status low.
// RQ6 - Frame length is a parameter.
// RQ7 - Two 32-bit registers: signature result and reference store.
// RQ8 - Signature zero means no error; non-zero drives the flag.
// RQ9 - Store loads delivered 32-bit CRC at configuration end.
// RQ10 - Stored reference feeds the compute-and-compare CRC.
// RQ11 - Load instruction makes store a 32-bit TDI-TDO scan chain.
// RQ12 - Store update never stalls checking.
// RQ13 - Host may inject a wrong reference and watch the flag.
// RQ14 - Generator is IEEE 802 32-bit polynomial, single calculation.
// RQ15 - Host selects chain with instruction 00 0001 0101 in user mode.
// RQ16 - Flag holds through next pass; cleared when a pass is clean.
// RQ17 - Checking starts on user mode and repeats until reconfig request.
// RQ18 - Checker clock is oscillator divided by power of two.
module config_memory_crc_checker #(
  parameter int unsigned MEM_BITS = cfg_crc_pkg::MEM_BITS_DEF,
  parameter int unsigned FRAME_BITS = cfg_crc_pkg::FRAME_BITS_DEF,
  parameter int unsigned DIV_N = cfg_crc_pkg::DIV_N_DEF,
  parameter bit ERR_DETECT_EN = 1'b1
) (
  input wire logic clk_i, // Configuration oscillator
  input wire logic rstn_i, // Async reset, active low
  input wire logic reconfig_request_n_i, // Reconfiguration request pin
  input wire logic cfg_active_i, // Configuration stage running
  input wire logic cfg_bit_valid_i, // Configuration bit strobe
  input wire logic cfg_bit_i, // Configuration bit
  input wire logic cfg_done_i, // Configuration end strobe
  input wire logic [31:0] cfg_crc_i, // Delivered whole-image CRC
  input wire logic user_mode_i, // Device in user mode
  input wire logic mem_bit_i, // Cell memory bit at mem_addr_o
  output logic [$clog2(MEM_BITS)-1:0] mem_addr_o, // Cell memory read index
  input wire logic tck_i, // Test clock pin
  input wire logic tdi_i, // Test data in pin
  input wire logic shift_dr_i, // TAP in Shift-DR
  input wire logic update_dr_i, // TAP in Update-DR
  input wire logic [9:0] ir_i, // Current TAP instruction
  output logic tdo_o, // Test data out
  output logic config_status_n_o, // Status drive level (always 0)
  output logic config_status_n_oe_o, // Low pulls status low
  output logic crc_error_o, // Error flag drive level (always 0)
  output logic crc_error_oe_o, // Low pulls flag low
  output logic [31:0] crc_signature_result_o, // Signature register
  output logic [31:0] crc_reference_store_o // Storage register
);
  localparam int unsigned AW = $clog2(MEM_BITS);

  //==============================================================
  // Input synchronisers
  logic [1:0] s_req, s_tck, s_tdi, s_sh, s_up;
  logic req_n, tck, tdi, shft, upd, tck_d;
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s_req <= '0;
      s_tck <= '0;
      s_tdi <= '0;
      s_sh <= '0;
      s_up <= '0;
      tck_d <= 1'b0;
    end else begin
      s_req <= {s_req[0], reconfig_request_n_i};
      s_tck <= {s_tck[0], tck_i};
      s_tdi <= {s_tdi[0], tdi_i};
      s_sh <= {s_sh[0], shift_dr_i};
      s_up <= {s_up[0], update_dr_i};
      tck_d <= s_tck[1];
    end
  end
  assign req_n = s_req[1];
  assign tck = s_tck[1];
  assign tdi = s_tdi[1];
  assign shft = s_sh[1];
  assign upd = s_up[1];

  //==============================================================
  // Clock divider: one checker step every 2^DIV_N oscillator cycles
  logic [8:0] div, next_div;
  logic tick;
  assign tick = (div == 9'((1 << DIV_N) - 1)); // RQ18
  always_comb begin
    next_div = tick ? 9'h000 : div + 9'h001;
  end
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      div <= 9'h000;
    end else begin
      div <= next_div;
    end
  end

  //==============================================================
  // Frame check during configuration
  logic frame_err;
  frame_crc16_check #(.FRAME_BITS(FRAME_BITS)) u_frame ( // RQ6
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .cfg_active_i(cfg_active_i),
    .bit_valid_i(cfg_bit_valid_i),
    .bit_i(cfg_bit_i),
    .frame_err_o(frame_err)
  );

  //==============================================================
  // Storage register with scan path
  logic [31:0] store, next_store, shreg, next_shreg;
  logic sel_chain, tck_rise;
  assign sel_chain = user_mode_i && (ir_i == cfg_crc_pkg::LOAD_CRC_STORE_CODE); // RQ15
  assign tck_rise = tck && !tck_d;
  always_comb begin
    next_store = store;
    next_shreg = shreg;
    if (cfg_done_i) begin
      next_store = cfg_crc_i; // RQ9
    end else if (sel_chain && tck_rise) begin
      // Shift stage kept apart so the live reference never half-updates
      if (shft) begin
        next_shreg = {tdi, shreg[31:1]}; // RQ11
      end else if (upd) begin
        next_store = shreg; // RQ11
      end
    end
    // Mirror tracks the store only while the host does not own the chain
    if (!sel_chain) begin
      next_shreg = next_store;
    end
  end
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      store <= cfg_crc_pkg::STORE_RESET;
      shreg <= cfg_crc_pkg::STORE_RESET;
    end else begin
      store <= next_store;
      shreg <= next_shreg;
    end
  end

  //==============================================================
  // User-mode pass over the whole cell memory
  typedef enum logic [1:0] {ST_IDLE, ST_SCAN, ST_CMP} pass_t;
  pass_t st, next_st;
  logic [AW-1:0] addr, next_addr;
  logic [31:0] crc, next_crc, step_crc, sig, next_sig;
  logic flag, next_flag;

  crc_step #(.W(32), .POLY(cfg_crc_pkg::CRC32_POLY)) u_step ( // RQ14
    .crc_i(crc),
    .bit_i(mem_bit_i),
    .crc_o(step_crc)
  );

  always_comb begin
    next_st = st;
    next_addr = addr;
    next_crc = crc;
    next_sig = sig;
    next_flag = flag;
    if (!req_n) begin
      next_st = ST_IDLE; // RQ17
      next_flag = 1'b0;
      next_sig = cfg_crc_pkg::SIG_RESET;
    end else if (tick) begin // RQ12
      case (st)
        ST_IDLE: begin
          if (user_mode_i) begin
            next_st = ST_SCAN; // RQ17
            next_addr = '0;
            next_crc = cfg_crc_pkg::CRC32_INIT;
          end
        end
        ST_SCAN: begin
          next_crc = step_crc; // RQ3
          next_addr = addr + 1'b1;
          if (addr == AW'(MEM_BITS - 1)) begin
            next_st = ST_CMP;
          end
        end
        ST_CMP: begin
          next_sig = crc ^ store; // RQ10
          next_flag = ((crc ^ store) != 32'h00000000); // RQ8
          next_st = user_mode_i ? ST_SCAN : ST_IDLE; // RQ16
          next_addr = '0;
          next_crc = cfg_crc_pkg::CRC32_INIT;
        end
        default: begin
          next_st = ST_IDLE;
        end
      endcase
    end
  end
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st <= ST_IDLE;
      addr <= '0;
      crc <= cfg_crc_pkg::CRC32_INIT;
      sig <= cfg_crc_pkg::SIG_RESET;
      flag <= 1'b0;
    end else begin
      st <= next_st;
      addr <= next_addr;
      crc <= next_crc;
      sig <= next_sig;
      flag <= next_flag;
    end
  end

  //==============================================================
  // Registered outputs
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tdo_o <= 1'b0;
      mem_addr_o <= '0;
      crc_error_o <= 1'b0;
      crc_error_oe_o <= 1'b0;
      config_status_n_o <= 1'b0;
      config_status_n_oe_o <= 1'b1;
      crc_signature_result_o <= cfg_crc_pkg::SIG_RESET;
      crc_reference_store_o <= cfg_crc_pkg::STORE_RESET;
    end else begin
      tdo_o <= shreg[0]; // RQ11
      mem_addr_o <= next_addr;
      crc_error_o <= 1'b0; // RQ2
      // Released means high by pull-up; disabled feature keeps it pulled low
      crc_error_oe_o <= ERR_DETECT_EN ? next_flag : 1'b0; // RQ1
      config_status_n_o <= 1'b0;
      config_status_n_oe_o <= !frame_err; // RQ5
      crc_signature_result_o <= next_sig; // RQ7
      crc_reference_store_o <= next_store;
    end
  end

  //==============================================================
  // Checks
  property p_flag_from_sig;
    @(posedge clk_i) disable iff (!rstn_i) flag == (sig != 32'h00000000);
  endproperty
  a_flag_from_sig: assert property (p_flag_from_sig) // RQ8
    else $error("flag disagrees with signature");

  property p_flag_hold;
    @(posedge clk_i) disable iff (!rstn_i)
      (flag && req_n && st != ST_CMP) |=> flag;
  endproperty
  a_flag_hold: assert property (p_flag_hold) // RQ16
    else $error("flag dropped mid pass");

  property p_pin_follows;
    @(posedge clk_i) disable iff (!rstn_i)
      ERR_DETECT_EN |-> ##1 (crc_error_oe_o == flag);
  endproperty
  a_pin_follows: assert property (p_pin_follows) // RQ1
    else $error("pin not following flag");

  property p_drive_low_only;
    @(posedge clk_i) disable iff (!rstn_i) crc_error_o == 1'b0;
  endproperty
  a_drive_low_only: assert property (p_drive_low_only) // RQ2
    else $error("flag pin driven high");

  property p_cfg_load;
    @(posedge clk_i) disable iff (!rstn_i) cfg_done_i |=> (store == $past(cfg_crc_i));
  endproperty
  a_cfg_load: assert property (p_cfg_load) // RQ9
    else $error("store not loaded at configuration end");

  property p_no_stall;
    @(posedge clk_i) disable iff (!rstn_i)
      (st == ST_SCAN && tick && req_n && addr != AW'(MEM_BITS - 1))
        |=> (addr == $past(addr) + 1'b1);
  endproperty
  a_no_stall: assert property (p_no_stall) // RQ12
    else $error("scan stalled");

  // Chain steps only on a synchronised test-clock rise
  sequence s_chain_shift;
    sel_chain && tck_rise && shft && !cfg_done_i;
  endsequence
  sequence s_chain_update;
    sel_chain && tck_rise && !shft && upd && !cfg_done_i;
  endsequence

  property p_chain_shift;
    @(posedge clk_i) disable iff (!rstn_i)
      s_chain_shift |=> (shreg == {$past(tdi), $past(shreg[31:1])});
  endproperty
  a_chain_shift: assert property (p_chain_shift) // RQ11
    else $error("scan chain did not shift");

  property p_chain_update;
    @(posedge clk_i) disable iff (!rstn_i) s_chain_update |=> (store == $past(shreg));
  endproperty
  a_chain_update: assert property (p_chain_update) // RQ11
    else $error("store not updated from scan chain");

  sequence s_cmp_step;
    st == ST_CMP && tick && req_n;
  endsequence

  property p_sig_update;
    @(posedge clk_i) disable iff (!rstn_i)
      s_cmp_step |=> (sig == ($past(crc) ^ $past(store)));
  endproperty
  a_sig_update: assert property (p_sig_update) // RQ10
    else $error("signature not crc against reference");

  property p_pass_start;
    @(posedge clk_i) disable iff (!rstn_i)
      (st == ST_IDLE && tick && req_n && user_mode_i) |=> (st == ST_SCAN && addr == '0);
  endproperty
  a_pass_start: assert property (p_pass_start) // RQ17
    else $error("pass did not start in user mode");

  property p_reset_req;
    @(posedge clk_i) disable iff (!rstn_i) !req_n |=> (st == ST_IDLE && !flag);
  endproperty
  a_reset_req: assert property (p_reset_req) // RQ17
    else $error("reconfig request did not stop checking");

  property p_status;
    @(posedge clk_i) disable iff (!rstn_i) frame_err |=> !config_status_n_oe_o;
  endproperty
  a_status: assert property (p_status) // RQ5
    else $error("status not pulled low on frame error");
endmodule : config_memory_crc_checker

// file: hdl/cfg_crc_pkg.sv
// Shared constants for the configuration memory CRC checker
package cfg_crc_pkg;
  localparam int unsigned CRC32_W = 32;
  localparam int unsigned CRC16_W = 16;
  localparam logic [31:0] CRC32_POLY = 32'h04C11DB7;
  localparam logic [31:0] CRC32_INIT = 32'hFFFFFFFF;
  localparam logic [15:0] CRC16_POLY = 16'h8005;
  localparam logic [15:0] CRC16_INIT = 16'h0000;
  localparam logic [31:0] STORE_RESET = 32'h00000000;
  localparam logic [31:0] SIG_RESET = 32'h00000000;
  localparam int unsigned IR_W = 10;
  localparam logic [9:0] LOAD_CRC_STORE_CODE = 10'h015;
  localparam int unsigned FRAME_BITS_DEF = 64;
  localparam int unsigned MEM_BITS_DEF = 256;
  localparam int unsigned DIV_N_DEF = 0;
  localparam int unsigned SYNC_STAGES = 2;
endpackage : cfg_crc_pkg

// file: hdl/crc_step.sv
// Serial CRC step shared by the frame and memory checkers
module crc_step #(
  parameter int unsigned W = 32,
  parameter logic [W-1:0] POLY = '0
) (
  input wire logic [W-1:0] crc_i, // Current remainder
  input wire logic bit_i, // Incoming bit
  output logic [W-1:0] crc_o // Next remainder
);
  always_comb begin
    if (crc_i[W-1] ^ bit_i) begin
      crc_o = {crc_i[W-2:0], 1'b0} ^ POLY;
    end else begin
      crc_o = {crc_i[W-2:0], 1'b0};
    end
  end
endmodule : crc_step

// file: hdl/frame_crc16_check.sv
// Per-frame 16-bit CRC check during configuration
module frame_crc16_check #(
  parameter int unsigned FRAME_BITS = cfg_crc_pkg::FRAME_BITS_DEF
) (
  input wire logic clk_i, // Configuration oscillator, undivided
  input wire logic rstn_i, // Async reset, active low
  input wire logic cfg_active_i, // Configuration stage running
  input wire logic bit_valid_i, // Configuration bit strobe
  input wire logic bit_i, // Configuration bit
  output logic frame_err_o // Sticky frame CRC mismatch
);
  localparam int unsigned TOTAL = FRAME_BITS + cfg_crc_pkg::CRC16_W;
  localparam int unsigned CW = $clog2(TOTAL + 1);
  logic [CW-1:0] cnt, next_cnt;
  logic [15:0] crc, next_crc, step_crc;
  logic [15:0] rx, next_rx;
  logic err, next_err;

  crc_step #(.W(16), .POLY(cfg_crc_pkg::CRC16_POLY)) u_step (
    .crc_i(crc),
    .bit_i(bit_i),
    .crc_o(step_crc)
  );

  always_comb begin
    next_cnt = cnt;
    next_crc = crc;
    next_rx = rx;
    next_err = err;
    if (cfg_active_i && bit_valid_i) begin
      if (cnt < CW'(FRAME_BITS)) begin
        next_crc = step_crc;
        next_cnt = cnt + 1'b1;
      end else begin
        // Embedded CRC shifts in while the frame result is held
        next_rx = {rx[14:0], bit_i}; // RQ4
        next_cnt = cnt + 1'b1;
        if (cnt == CW'(TOTAL - 1)) begin
          if ({rx[14:0], bit_i} != crc) begin
            next_err = 1'b1; // RQ5
          end
          next_cnt = '0;
          next_crc = cfg_crc_pkg::CRC16_INIT;
        end
      end
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt <= '0;
      crc <= cfg_crc_pkg::CRC16_INIT;
      rx <= '0;
      err <= 1'b0;
    end else begin
      cnt <= next_cnt;
      crc <= next_crc;
      rx <= next_rx;
      err <= next_err;
    end
  end
  assign frame_err_o = err;

  property p_frame_err_sticky;
    @(posedge clk_i) disable iff (!rstn_i) err |=> err;
  endproperty
  a_frame_err_sticky: assert property (p_frame_err_sticky) // RQ5
    else $error("frame error cleared");
endmodule : frame_crc16_check

// file: testbench/cell_mem_model.sv
// Far-side model: configuration cell memory and pulled-up open-drain pins
module cell_mem_model #(
  parameter int unsigned MEM_BITS = 64
) (
  input wire logic [$clog2(MEM_BITS)-1:0] mem_addr_i, // Read index
  output logic mem_bit_o, // Cell bit
  input wire logic err_drive_i, // Flag drive level
  input wire logic err_oe_i, // Low pulls flag low
  input wire logic stat_drive_i, // Status drive level
  input wire logic stat_oe_i, // Low pulls status low
  output logic err_pin_o, // Resolved flag pin
  output logic stat_pin_o // Resolved status pin
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [MEM_BITS-1:0] cells;
  initial begin
    for (int i = 0; i < MEM_BITS; i++) begin
      cells[i] = ((i * 7) % 5) < 2;
    end
  end
  // Same-cycle read, as the checker expects
  assign mem_bit_o = cells[mem_addr_i];
  // Pull-ups win whenever nobody pulls low
  assign err_pin_o = err_oe_i ? 1'h1 : err_drive_i;
  assign stat_pin_o = stat_oe_i ? 1'h1 : stat_drive_i;
endmodule : cell_mem_model

// file: testbench/config_memory_crc_checker_bench.sv
// Self-checking bench for the configuration memory CRC checker
`define chk(got, exp) begin cmp_count++; if ((got) !== (exp)) begin miscompares++; \
  $display("wrong value at %0t: got %0h expected %0h", $time, (got), (exp)); end end
module config_memory_crc_checker_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned MB = 64;
  localparam int unsigned FB = 16;
  localparam int unsigned DN = 1;
  // Two full passes of (MB + 1) ticks at one tick per 2 clocks, plus sync slack
  localparam int unsigned PASS_WAIT = 300;
  logic clk_i, rstn_i, reconfig_request_n_i, cfg_active_i, cfg_bit_valid_i, cfg_bit_i;
  logic cfg_done_i, user_mode_i, tck_i, tdi_i, shift_dr_i, update_dr_i, mem_bit, tdo;
  logic [31:0] cfg_crc_i, sig, store, good;
  logic [9:0] ir_i;
  logic [5:0] mem_addr;
  logic st_d, st_oe, er_d, er_oe, err_pin, stat_pin;
  int miscompares, cmp_count, cycles;

  config_memory_crc_checker #(.MEM_BITS(MB), .FRAME_BITS(FB), .DIV_N(DN),
    .ERR_DETECT_EN(1'h1)) uut (.clk_i(clk_i), .rstn_i(rstn_i),
    .reconfig_request_n_i(reconfig_request_n_i), .cfg_active_i(cfg_active_i),
    .cfg_bit_valid_i(cfg_bit_valid_i), .cfg_bit_i(cfg_bit_i), .cfg_done_i(cfg_done_i),
    .cfg_crc_i(cfg_crc_i), .user_mode_i(user_mode_i), .mem_bit_i(mem_bit),
    .mem_addr_o(mem_addr), .tck_i(tck_i), .tdi_i(tdi_i), .shift_dr_i(shift_dr_i),
    .update_dr_i(update_dr_i), .ir_i(ir_i), .tdo_o(tdo), .config_status_n_o(st_d),
    .config_status_n_oe_o(st_oe), .crc_error_o(er_d), .crc_error_oe_o(er_oe),
    .crc_signature_result_o(sig), .crc_reference_store_o(store));
  cell_mem_model #(.MEM_BITS(MB)) pm (.mem_addr_i(mem_addr), .mem_bit_o(mem_bit),
    .err_drive_i(er_d), .err_oe_i(er_oe), .stat_drive_i(st_d), .stat_oe_i(st_oe),
    .err_pin_o(err_pin), .stat_pin_o(stat_pin));

  //==========================================================
  // Reference arithmetic
  function automatic logic [31:0] crc32(input logic [MB-1:0] c);
    logic [31:0] r;
    r = cfg_crc_pkg::CRC32_INIT;
    for (int i = 0; i < MB; i++) begin
      r = {r[30:0], 1'h0} ^ ((r[31] ^ c[i]) ? cfg_crc_pkg::CRC32_POLY : 32'h0);
    end
    return r;
  endfunction : crc32
  function automatic logic [15:0] crc16(input logic [FB-1:0] d);
    logic [15:0] r;
    r = cfg_crc_pkg::CRC16_INIT;
    for (int i = FB - 1; i >= 0; i--) begin
      r = {r[14:0], 1'h0} ^ ((r[15] ^ d[i]) ? cfg_crc_pkg::CRC16_POLY : 16'h0);
    end
    return r;
  endfunction : crc16

  //==========================================================
  // Drivers
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask : tick
  task automatic send_frame(input logic [15:0] d, input logic [15:0] c);
    logic [31:0] w;
    w = {d, c};
    for (int i = 31; i >= 0; i--) begin
      @(posedge clk_i);
      cfg_bit_valid_i <= 1'h1;
      cfg_bit_i <= w[i];
    end
    @(posedge clk_i);
    cfg_bit_valid_i <= 1'h0;
    tick(3);
  endtask : send_frame
  // Slow test clock so the 2-flop synchronisers see every edge
  task automatic tck_pulse(input logic chk_en, input logic exp);
    tick(3);
    if (chk_en) `chk(tdo, exp)
    tck_i <= 1'h1;
    tick(3);
    tck_i <= 1'h0;
  endtask : tck_pulse
  // Old reference leaves on tdo, LSB first, while the new one shifts in
  task automatic jtag_load(input logic [9:0] ir, input logic [31:0] v,
    input logic [31:0] old);
    @(posedge clk_i);
    ir_i <= ir;
    shift_dr_i <= 1'h1;
    for (int i = 0; i < 32; i++) begin
      tdi_i <= v[i];
      tck_pulse(ir == cfg_crc_pkg::LOAD_CRC_STORE_CODE, old[i]);
    end
    shift_dr_i <= 1'h0;
    update_dr_i <= 1'h1;
    tck_pulse(1'h0, 1'h0);
    update_dr_i <= 1'h0;
    tick(6);
  endtask : jtag_load

  //==========================================================
  // Scenarios
  task automatic t_reset();
    `chk(st_oe, 1'h1)
    `chk(err_pin, 1'h0)
    `chk(sig, 32'h0)
    `chk(store, 32'h0)
  endtask : t_reset
  task automatic t_config();
    cfg_active_i <= 1'h1;
    send_frame(16'hC3A5, crc16(16'hC3A5));
    `chk(stat_pin, 1'h1)
    send_frame(16'h5A0F, crc16(16'h5A0F) ^ 16'h0001);
    `chk(stat_pin, 1'h0)
    cfg_crc_i <= good;
    cfg_done_i <= 1'h1;
    @(posedge clk_i);
    cfg_done_i <= 1'h0;
    cfg_active_i <= 1'h0;
    tick(2);
    `chk(store, good)
  endtask : t_config
  task automatic t_clean();
    user_mode_i <= 1'h1;
    tick(PASS_WAIT);
    `chk(sig, 32'h0)
    `chk(err_pin, 1'h0)
  endtask : t_clean
  task automatic t_inject();
    jtag_load(10'h016, 32'h1234_5678, good);
    `chk(store, good)
    jtag_load(cfg_crc_pkg::LOAD_CRC_STORE_CODE, good ^ 32'h0000_0100, good);
    `chk(store, good ^ 32'h0000_0100)
    tick(PASS_WAIT);
    `chk(sig, 32'h0000_0100)
    `chk(err_pin, 1'h1)
    repeat (150) begin
      @(posedge clk_i);
      `chk(err_pin, 1'h1)
    end
  endtask : t_inject
  task automatic t_restore();
    jtag_load(cfg_crc_pkg::LOAD_CRC_STORE_CODE, good, good ^ 32'h0000_0100);
    tick(PASS_WAIT);
    `chk(sig, 32'h0)
    `chk(err_pin, 1'h0)
  endtask : t_restore
  task automatic t_soft();
    @(posedge clk_i);
    pm.cells[9] <= ~pm.cells[9];
    tick(PASS_WAIT);
    `chk(sig, crc32(pm.cells) ^ good)
    `chk(err_pin, 1'h1)
  endtask : t_soft
  task automatic t_reconfig();
    reconfig_request_n_i <= 1'h0;
    tick(8);
    `chk(err_pin, 1'h0)
    reconfig_request_n_i <= 1'h1;
    tick(PASS_WAIT);
    `chk(err_pin, 1'h1)
  endtask : t_reconfig

  //==========================================================
  // Run control
  task automatic print_verdict();
    $display("comparisons %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : print_verdict
  initial begin
    clk_i = 1'h0;
    forever #4 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 10000) begin
      miscompares++;
      print_verdict();
    end
  end
  initial begin
    {rstn_i, cfg_active_i, cfg_bit_valid_i, cfg_bit_i, cfg_done_i, user_mode_i} = '0;
    {tck_i, tdi_i, shift_dr_i, update_dr_i} = '0;
    reconfig_request_n_i = 1'h1;
    cfg_crc_i = 32'h0;
    ir_i = 10'h0;
    tick(3);
    rstn_i <= 1'h1;
    good = crc32(pm.cells);
    tick(1);
    t_reset();
    t_config();
    t_clean();
    t_inject();
    t_restore();
    t_soft();
    t_reconfig();
    print_verdict();
  end
endmodule : config_memory_crc_checker_bench
